//--- hdl/tap_map.svh
// constants of the boundary-scan test access port
`ifndef TAP_MAP_SVH
`define TAP_MAP_SVH

// ==========================================================
// instruction register
`define TAP_IR_W 5
`define TAP_IR_CAPTURE 5'h01
`define TAP_OP_EXTEST 5'h00
`define TAP_OP_SAMPLE 5'h01
`define TAP_OP_CLAMP 5'h02
`define TAP_OP_HIGHZ 5'h03
`define TAP_OP_IDCODE 5'h11
`define TAP_OP_BYPASS 5'h1f

// ==========================================================
// identification word layout
`define TAP_ID_W 32
`define TAP_ID_VER_MSB 31
`define TAP_ID_VER_LSB 28
`define TAP_ID_PART_MSB 27
`define TAP_ID_PART_LSB 12
`define TAP_ID_MAKER_MSB 11
`define TAP_ID_MAKER_LSB 1
`define TAP_ID_ONE_BIT 0
`define TAP_ID_ONE 1'h1

`endif

//--- hdl/tap_pkg.sv
// types and instruction decoders of the boundary-scan port
`include "tap_map.svh"
package tap_pkg;

   // ==========================================================
   // sixteen controller states
   typedef enum logic [3:0] {
      ST_TLR, ST_RTI, ST_SEL_DR, ST_CAP_DR, ST_SHF_DR, ST_EX1_DR, ST_PAU_DR,
      ST_EX2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SHF_IR, ST_EX1_IR,
      ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
   } tap_state_t;

   typedef logic [`TAP_IR_W-1:0] tap_ir_t;

   // ==========================================================
   // decoders; sel_id_f and sel_bsr_f serve the tck domain, drive_f and highz_f the mclk domain
   function automatic logic sel_id_f(input tap_ir_t ir);
      return ir == `TAP_OP_IDCODE;
   endfunction : sel_id_f

   // boundary register is the serial path
   function automatic logic sel_bsr_f(input tap_ir_t ir);
      return (ir == `TAP_OP_EXTEST) || (ir == `TAP_OP_SAMPLE);
   endfunction : sel_bsr_f

   // pins follow the update register
   function automatic logic drive_f(input tap_ir_t ir);
      return (ir == `TAP_OP_EXTEST) || (ir == `TAP_OP_CLAMP);
   endfunction : drive_f

   function automatic logic highz_f(input tap_ir_t ir);
      return ir == `TAP_OP_HIGHZ;
   endfunction : highz_f

endpackage : tap_pkg

//--- hdl/tap_if.sv
// controller state strobes shared between the tap modules
`timescale 1ns/1ps
`default_nettype none
interface tap_if;
   logic in_reset; // test-logic-reset
   logic cap_dr;
   logic shf_dr;
   logic upd_dr;
   logic cap_ir;
   logic shf_ir;
   logic upd_ir;
   modport ctrl (output in_reset, cap_dr, shf_dr, upd_dr, cap_ir, shf_ir, upd_ir);
   modport user (input in_reset, cap_dr, shf_dr, upd_dr, cap_ir, shf_ir, upd_ir);
endinterface : tap_if
`default_nettype wire

//--- hdl/tap_fsm.sv
// sixteen-state test access port controller on the test clock
`timescale 1ns/1ps
`default_nettype none
module tap_fsm
   import tap_pkg::*;
(
   input wire logic i_tck,
   input wire logic i_arst_n,
   input wire logic i_tms,
   tap_if.ctrl tap
);

   tap_state_t st_q; // current state
   tap_state_t st_d;

   // ==========================================================
   // next state from tms
   always_comb
   begin
      case (st_q)
         ST_TLR:    st_d = i_tms ? ST_TLR : ST_RTI;
         ST_RTI:    st_d = i_tms ? ST_SEL_DR : ST_RTI;
         ST_SEL_DR: st_d = i_tms ? ST_SEL_IR : ST_CAP_DR;
         ST_CAP_DR: st_d = i_tms ? ST_EX1_DR : ST_SHF_DR;
         ST_SHF_DR: st_d = i_tms ? ST_EX1_DR : ST_SHF_DR;
         ST_EX1_DR: st_d = i_tms ? ST_UPD_DR : ST_PAU_DR;
         ST_PAU_DR: st_d = i_tms ? ST_EX2_DR : ST_PAU_DR;
         ST_EX2_DR: st_d = i_tms ? ST_UPD_DR : ST_SHF_DR;
         ST_UPD_DR: st_d = i_tms ? ST_SEL_DR : ST_RTI;
         ST_SEL_IR: st_d = i_tms ? ST_TLR : ST_CAP_IR;
         ST_CAP_IR: st_d = i_tms ? ST_EX1_IR : ST_SHF_IR;
         ST_SHF_IR: st_d = i_tms ? ST_EX1_IR : ST_SHF_IR;
         ST_EX1_IR: st_d = i_tms ? ST_UPD_IR : ST_PAU_IR;
         ST_PAU_IR: st_d = i_tms ? ST_EX2_IR : ST_PAU_IR;
         ST_EX2_IR: st_d = i_tms ? ST_UPD_IR : ST_SHF_IR;
         ST_UPD_IR: st_d = i_tms ? ST_SEL_DR : ST_RTI;
         default:   st_d = ST_TLR; // recover from any stray code
      endcase
   end

   // state register, advanced on rising tck
   always_ff @(posedge i_tck or negedge i_arst_n)
   begin
      if (!i_arst_n)
         st_q <= ST_TLR;
      else
         st_q <= st_d; // RULE_10
   end

   // ==========================================================
   // decoded strobes
   assign tap.in_reset = (st_q == ST_TLR);
   assign tap.cap_dr = (st_q == ST_CAP_DR);
   assign tap.shf_dr = (st_q == ST_SHF_DR);
   assign tap.upd_dr = (st_q == ST_UPD_DR);
   assign tap.cap_ir = (st_q == ST_CAP_IR);
   assign tap.shf_ir = (st_q == ST_SHF_IR);
   assign tap.upd_ir = (st_q == ST_UPD_IR);

endmodule : tap_fsm
`default_nettype wire

//--- hdl/word_sync.sv
// toggle handshake that carries a stable word into another clock domain
`timescale 1ns/1ps
`default_nettype none
module word_sync #(
   parameter int W = 8,
   parameter logic [W-1:0] RST_WORD = '0
) (
   input wire logic i_src_clk,
   input wire logic i_src_rst_n,
   input wire logic i_load, // word changed this edge
   input wire logic [W-1:0] i_word, // source flops, stable between loads
   input wire logic i_dst_clk,
   input wire logic i_dst_rst_n,
   output logic [W-1:0] o_word
);

   logic tgl_q; // source toggle
   logic tgl_d;
   logic s1_q; // first stage, read only by s2_q
   logic s2_q;
   logic s3_q;
   logic [W-1:0] word_q;
   logic [W-1:0] word_d;

   // ==========================================================
   // source side: flip on each load
   always_comb
   begin
      tgl_d = tgl_q ^ i_load;
   end

   always_ff @(posedge i_src_clk or negedge i_src_rst_n)
   begin
      if (!i_src_rst_n)
         tgl_q <= 1'b0;
      else
         tgl_q <= tgl_d;
   end

   // ==========================================================
   // destination side: the word is already stable once the toggle lands
   always_comb
   begin
      word_d = (s2_q ^ s3_q) ? i_word : word_q;
   end

   always_ff @(posedge i_dst_clk or negedge i_dst_rst_n)
   begin
      if (!i_dst_rst_n)
      begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
         word_q <= RST_WORD;
      end
      else
      begin
         s1_q <= tgl_q;
         s2_q <= s1_q;
         s3_q <= s2_q;
         word_q <= word_d;
      end
   end

   assign o_word = word_q;

endmodule : word_sync
`default_nettype wire

//--- hdl/boundary_scan_tap.sv
// boundary-scan test access port with pin control in the system domain
//
// Functional notes
// RULE_01: four pins: tms, tck, tdi in; tdo out
// RULE_02: extest drives preloaded outputs, captures all inputs
// RULE_03: sample snapshots pins; preload shifts new values
// RULE_04: idcode shifts the 32-bit identification word
// RULE_05: clamp holds pins from boundary, selects bypass
// RULE_06: highz floats every output, selects bypass
// RULE_07: bypass: one register stage tdi to tdo
// RULE_08: id word: version, part, maker, lsb one
// RULE_09: five-bit instruction; reserved codes act as bypass
// RULE_10: standard states; tdo on falling edge, shift only
`timescale 1ns/1ps
`default_nettype none
`include "tap_map.svh"
module boundary_scan_tap
   import tap_pkg::*;
#(
   parameter int IN_W = 4, // boundary input cells
   parameter int OUT_W = 4, // boundary output cells
   parameter logic [3:0] ID_VERSION = 4'ha, // arbitrary value
   parameter logic [15:0] ID_PART = 16'h5a3c, // arbitrary value
   parameter logic [10:0] ID_MAKER = 11'h2b5 // arbitrary value
) (
   input wire logic i_mclk,
   input wire logic i_arst_n,
   input wire logic i_tck,
   input wire logic i_tms,
   input wire logic i_tdi,
   output logic o_tdo,
   output logic o_tdo_oe,
   input wire logic [IN_W-1:0] i_pin_in,
   output logic [IN_W-1:0] o_core_in,
   input wire logic [OUT_W-1:0] i_core_out,
   input wire logic i_core_oe,
   output logic [OUT_W-1:0] o_pin_out,
   output logic [OUT_W-1:0] o_pin_oe
);

   // ==========================================================
   // widths and constants
   localparam int BSR_W = IN_W + OUT_W + 1; // inputs, outputs, one enable cell
   localparam int UPD_W = OUT_W + 1; // update holds outputs and enable
   localparam int XW = `TAP_IR_W + UPD_W; // word handed to the system side
   localparam logic [`TAP_ID_W-1:0] ID_WORD = {ID_VERSION, ID_PART, ID_MAKER, `TAP_ID_ONE};
   localparam logic [XW-1:0] XRST = {`TAP_OP_IDCODE, {UPD_W{1'b0}}};

   tap_if tap (); // controller strobes

   // tck domain state
   logic [BSR_W-1:0] smp1_q; // first sampling stage, read only by smp2_q
   logic [BSR_W-1:0] smp2_q; // pins and core outputs seen on tck
   tap_ir_t ir_q; // active instruction
   tap_ir_t ir_d;
   tap_ir_t ir_sh_q; // instruction shift stage
   tap_ir_t ir_sh_d;
   logic [BSR_W-1:0] bsr_q; // boundary shift cells
   logic [BSR_W-1:0] bsr_d;
   logic [UPD_W-1:0] upd_q; // boundary update latches
   logic [UPD_W-1:0] upd_d;
   logic [`TAP_ID_W-1:0] id_q; // identification shift
   logic [`TAP_ID_W-1:0] id_d;
   logic byp_q; // single bypass stage
   logic byp_d;
   logic tdo_q;
   logic tdo_d;
   logic tdo_oe_q;
   logic tdo_oe_d;
   logic xload; // word to the system side changed

   // mclk domain state
   logic [XW-1:0] xword; // instruction and update word on mclk
   tap_ir_t ir_m;
   logic [UPD_W-1:0] upd_m;
   logic [IN_W-1:0] pin1_q; // first stage, read only by pin2_q
   logic [IN_W-1:0] pin2_q;
   logic [OUT_W-1:0] pout_q;
   logic [OUT_W-1:0] pout_d;
   logic [OUT_W-1:0] poe_q;
   logic [OUT_W-1:0] poe_d;

   // ==========================================================
   // controller
   tap_fsm u_fsm (
      .i_tck(i_tck),
      .i_arst_n(i_arst_n),
      .i_tms(i_tms),
      .tap(tap.ctrl)
   );

   // ==========================================================
   // pin sampling on tck, two stages since pins and core run on other clocks
   always_ff @(posedge i_tck or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         smp1_q <= '0;
         smp2_q <= '0;
      end
      else
      begin
         smp1_q <= {i_core_oe, i_core_out, i_pin_in};
         smp2_q <= smp1_q;
      end
   end

   // ==========================================================
   // instruction, data shift paths and update latches: next values
   always_comb
   begin
      ir_d = ir_q;
      ir_sh_d = ir_sh_q;
      bsr_d = bsr_q;
      upd_d = upd_q;
      id_d = id_q;
      byp_d = byp_q;
      // instruction register path
      if (tap.cap_ir)
         ir_sh_d = `TAP_IR_CAPTURE;
      else if (tap.shf_ir)
         ir_sh_d = {i_tdi, ir_sh_q[`TAP_IR_W-1:1]}; // RULE_09
      if (tap.in_reset)
         ir_d = `TAP_OP_IDCODE; // reset selects the identification path
      else if (tap.upd_ir)
         ir_d = ir_sh_q; // RULE_09
      // data register paths
      if (tap.cap_dr)
      begin
         if (sel_id_f(ir_q))
            id_d = ID_WORD; // RULE_04 RULE_08
         else if (sel_bsr_f(ir_q))
            bsr_d = smp2_q; // RULE_02 RULE_03
         else
            byp_d = 1'b0; // RULE_05 RULE_06 RULE_09
      end
      else if (tap.shf_dr)
      begin
         if (sel_id_f(ir_q))
            id_d = {i_tdi, id_q[`TAP_ID_W-1:1]}; // RULE_04
         else if (sel_bsr_f(ir_q))
            bsr_d = {i_tdi, bsr_q[BSR_W-1:1]}; // RULE_03
         else
            byp_d = i_tdi; // RULE_07
      end
      // clamp leaves the latches alone, so pins stay put
      if (tap.upd_dr && sel_bsr_f(ir_q))
         upd_d = bsr_q[BSR_W-1:IN_W]; // RULE_03
   end

   // register the paths on rising tck
   always_ff @(posedge i_tck or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         ir_q <= `TAP_OP_IDCODE;
         ir_sh_q <= '0;
         bsr_q <= '0;
         upd_q <= '0;
         id_q <= '0;
         byp_q <= 1'b0;
      end
      else
      begin
         ir_q <= ir_d;
         ir_sh_q <= ir_sh_d;
         bsr_q <= bsr_d;
         upd_q <= upd_d;
         id_q <= id_d;
         byp_q <= byp_d;
      end
   end

   // ==========================================================
   // tdo: chosen path, launched on falling tck, enabled in shift only
   always_comb
   begin
      tdo_oe_d = tap.shf_ir || tap.shf_dr; // RULE_10
      if (tap.shf_ir)
         tdo_d = ir_sh_q[0];
      else if (sel_id_f(ir_q))
         tdo_d = id_q[0]; // RULE_04
      else if (sel_bsr_f(ir_q))
         tdo_d = bsr_q[0];
      else
         tdo_d = byp_q; // RULE_07 RULE_09
   end

   always_ff @(negedge i_tck or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         tdo_q <= 1'b0;
         tdo_oe_q <= 1'b0;
      end
      else
      begin
         tdo_q <= tdo_d; // RULE_10
         tdo_oe_q <= tdo_oe_d; // RULE_01
      end
   end

   assign o_tdo = tdo_q;
   assign o_tdo_oe = tdo_oe_q;

   // ==========================================================
   // hand instruction and latches to the system clock
   assign xload = tap.upd_ir || tap.upd_dr || tap.in_reset;

   word_sync #(
      .W(XW),
      .RST_WORD(XRST)
   ) u_xsync (
      .i_src_clk(i_tck),
      .i_src_rst_n(i_arst_n),
      .i_load(xload),
      .i_word({ir_q, upd_q}),
      .i_dst_clk(i_mclk),
      .i_dst_rst_n(i_arst_n),
      .o_word(xword)
   );

   assign ir_m = xword[XW-1:UPD_W];
   assign upd_m = xword[UPD_W-1:0];

   // ==========================================================
   // pin drivers on mclk: normal, boundary-driven or floated
   always_comb
   begin
      if (highz_f(ir_m))
      begin
         pout_d = i_core_out;
         poe_d = '0; // RULE_06
      end
      else if (drive_f(ir_m))
      begin
         pout_d = upd_m[OUT_W-1:0]; // RULE_02 RULE_05
         poe_d = {OUT_W{upd_m[OUT_W]}};
      end
      else
      begin
         pout_d = i_core_out; // sample/preload leaves the core in charge
         poe_d = {OUT_W{i_core_oe}};
      end
   end

   // pin registers and input synchroniser toward the core
   always_ff @(posedge i_mclk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         pout_q <= '0;
         poe_q <= '0;
         pin1_q <= '0;
         pin2_q <= '0;
      end
      else
      begin
         pout_q <= pout_d;
         poe_q <= poe_d;
         pin1_q <= i_pin_in;
         pin2_q <= pin1_q;
      end
   end

   assign o_pin_out = pout_q;
   assign o_pin_oe = poe_q;
   assign o_core_in = pin2_q;

   // ==========================================================
   // checks on the test clock
   a_tdo_shift_only: assert property ( // RULE_10
      @(posedge i_tck) disable iff (!i_arst_n)
      o_tdo_oe == (tap.shf_ir || tap.shf_dr))
      else $error("tdo enable outside shift states");
   a_tms_reset: assert property ( // RULE_10
      @(posedge i_tck) disable iff (!i_arst_n)
      i_tms [*5] |=> tap.in_reset)
      else $error("five tms highs did not reach reset");
   a_ir_capture: assert property ( // RULE_09
      @(posedge i_tck) disable iff (!i_arst_n)
      tap.cap_ir |=> ir_sh_q == `TAP_IR_CAPTURE)
      else $error("wrong instruction capture value");
   a_ir_update: assert property ( // RULE_09
      @(posedge i_tck) disable iff (!i_arst_n)
      tap.upd_ir |=> ir_q == $past(ir_sh_q))
      else $error("instruction not updated");
   a_id_fields: assert property ( // RULE_08
      @(posedge i_tck) disable iff (!i_arst_n)
      (tap.cap_dr && sel_id_f(ir_q)) |=>
      id_q[`TAP_ID_VER_MSB:`TAP_ID_VER_LSB] == ID_VERSION &&
      id_q[`TAP_ID_PART_MSB:`TAP_ID_PART_LSB] == ID_PART &&
      id_q[`TAP_ID_MAKER_MSB:`TAP_ID_MAKER_LSB] == ID_MAKER &&
      id_q[`TAP_ID_ONE_BIT])
      else $error("identification word fields wrong");
   a_bypass_stage: assert property ( // RULE_07
      @(posedge i_tck) disable iff (!i_arst_n)
      // tdo launched at the falling edge in between is seen at the next rising edge
      (tap.shf_dr && !sel_id_f(ir_q) && !sel_bsr_f(ir_q)) ##1 tap.shf_dr
      |-> o_tdo == $past(i_tdi))
      else $error("bypass path is not one stage");

   // checks on the system clock
   a_highz_pins: assert property ( // RULE_06
      @(posedge i_mclk) disable iff (!i_arst_n)
      highz_f(ir_m) |=> o_pin_oe == '0)
      else $error("outputs enabled under highz");
   a_extest_drive: assert property ( // RULE_02
      @(posedge i_mclk) disable iff (!i_arst_n)
      drive_f(ir_m) |=> o_pin_out == $past(upd_m[OUT_W-1:0]))
      else $error("pins not driven from boundary latches");
   a_clamp_hold: assert property ( // RULE_05
      @(posedge i_mclk) disable iff (!i_arst_n)
      (ir_m == `TAP_OP_CLAMP) [*2] |=> $stable(o_pin_out) && $stable(o_pin_oe))
      else $error("pins moved while clamp active");

   // main scenarios
   c_id_read: cover property (@(posedge i_tck) tap.shf_dr && sel_id_f(ir_q));
   c_extest: cover property (@(posedge i_mclk) ir_m == `TAP_OP_EXTEST);
   c_highz: cover property (@(posedge i_mclk) highz_f(ir_m));
   c_bypass: cover property (@(posedge i_tck) tap.shf_dr && ir_q == `TAP_OP_BYPASS);

endmodule : boundary_scan_tap
`default_nettype wire

//--- sim/jtag_tester.sv
// test controller model that drives the test access pins
`timescale 1ns/1ps
`default_nettype none
module jtag_tester (
   output logic o_tck,
   output logic o_tms,
   output logic o_tdi,
   input wire logic i_tdo,
   input wire logic i_tdo_oe
);
   // ==========================================
   // idle levels at time zero
   initial
   begin
      o_tck = 1'b0;
      o_tms = 1'b1;
      o_tdi = 1'b0;
   end

   // ==========================================
   // one test clock period; the clock stands still between calls
   // pins change only while the clock is low, tdo is taken at the rising edge
   task automatic step(input logic tms, input logic tdi, input logic sh,
                       output logic tdo, output logic oe);
      o_tms = tms;
      o_tdi = sh ? tdi : ~o_tdi; // idle data toggles so a stale bit never passes
      #80 o_tck = 1'b1;
      tdo = i_tdo;
      oe = i_tdo_oe;
      #80 o_tck = 1'b0;
   endtask : step
endmodule : jtag_tester
`default_nettype wire

//--- sim/tb.sv
// self-checking bench of the boundary-scan port
`timescale 1ns/1ps
`default_nettype none
`include "tap_map.svh"
module tb;
   // ==========================================
   // identity and limits
   localparam logic [3:0] VER = 4'h3; // arbitrary value
   localparam logic [15:0] PART = 16'h2468; // arbitrary value
   localparam logic [10:0] MAKER = 11'h135; // arbitrary value
   localparam logic [63:0] ID = {32'h0, VER, PART, MAKER, `TAP_ID_ONE};
   localparam int LIMIT = 20000; // mclk cycles, about five times the run

   typedef struct packed {logic [4:0] op; logic [1:0] kind; logic [1:0] pins;} row_t;
   // kind: 0 id word, 1 single bit, 2 boundary; pins: 0 core, 1 latches, 2 floating
   row_t rows [9] = '{'{`TAP_OP_SAMPLE, 2'h2, 2'h0}, '{`TAP_OP_CLAMP, 2'h1, 2'h1},
      '{`TAP_OP_EXTEST, 2'h2, 2'h1}, '{`TAP_OP_HIGHZ, 2'h1, 2'h2},
      '{`TAP_OP_IDCODE, 2'h0, 2'h0}, '{`TAP_OP_BYPASS, 2'h1, 2'h0},
      '{5'h04, 2'h1, 2'h0}, '{5'h10, 2'h1, 2'h0}, '{5'h1e, 2'h1, 2'h0}};

   logic i_mclk = 1'b0;
   logic i_arst_n = 1'b0;
   logic i_tck, i_tms, i_tdi, o_tdo, o_tdo_oe;
   logic [3:0] i_pin_in = 4'h0;
   logic [3:0] i_core_out = 4'h0;
   logic i_core_oe = 1'b0;
   logic [3:0] o_core_in, o_pin_out, o_pin_oe;
   int fail_count = 0;
   int num_checks = 0;
   int cyc = 0;

   always #12.5 i_mclk = ~i_mclk;

   boundary_scan_tap #(.ID_VERSION(VER), .ID_PART(PART), .ID_MAKER(MAKER)) dut_u (
      .i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_tck(i_tck), .i_tms(i_tms),
      .i_tdi(i_tdi), .o_tdo(o_tdo), .o_tdo_oe(o_tdo_oe), .i_pin_in(i_pin_in),
      .o_core_in(o_core_in), .i_core_out(i_core_out), .i_core_oe(i_core_oe),
      .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe));

   jtag_tester tester_u (.o_tck(i_tck), .o_tms(i_tms), .o_tdi(i_tdi),
      .i_tdo(o_tdo), .i_tdo_oe(o_tdo_oe));

   // ==========================================
   // compares and closing
   task automatic chk_ser(input logic [63:0] got, input logic [63:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_ser

   task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_pin

   task automatic conclude;
      $display("checks=%0d mismatches=%0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : conclude

   // a hang counts as a mismatch
   always @(posedge i_mclk)
   begin
      cyc++;
      if (cyc == LIMIT)
      begin
         fail_count++;
         conclude();
      end
   end

   // ==========================================
   // serial helpers; tms sequences go lsb first
   task automatic nav(input logic [7:0] seq, input int n);
      logic d;
      logic e;
      for (int i = 0; i < n; i++)
         tester_u.step(seq[i], 1'b0, 1'b0, d, e);
   endtask : nav

   // shift n bits, leaving on the last; oe tells whether every sample was driven
   task automatic shift(input int n, input logic [63:0] din,
                        output logic [63:0] dout, output logic oe);
      logic d;
      logic e;
      dout = '0;
      oe = 1'b1;
      for (int i = 0; i < n; i++)
      begin
         tester_u.step(i == n - 1, din[i], 1'b1, d, e);
         dout[i] = d;
         oe = oe & e;
      end
   endtask : shift

   // from idle: select-dr, select-ir, capture, shift, update, idle
   task automatic ir_load(input logic [4:0] op, output logic [63:0] cap);
      logic e;
      nav(8'h03, 4);
      shift(5, {59'h0, op}, cap, e);
      nav(8'h01, 2);
      chk_pin({6'h0, e, o_tdo_oe}, 8'h02);
   endtask : ir_load

   task automatic dr_rw(input int n, input logic [63:0] din, output logic [63:0] dout);
      logic e;
      nav(8'h01, 3);
      shift(n, din, dout, e);
      nav(8'h01, 2);
      chk_pin({6'h0, e, o_tdo_oe}, 8'h02);
   endtask : dr_rw

   // captured word comes out first, then the bits shifted in; only 40 bits are read back
   function automatic logic [63:0] stream(input int len, input logic [63:0] cap,
                                          input logic [63:0] din);
      return ((din << len) | (cap & ((64'h1 << len) - 64'h1))) & 64'hff_ffff_ffff;
   endfunction : stream

   // ==========================================
   // main sequence
   initial
   begin
      logic [63:0] got;
      logic [63:0] pat;
      logic [63:0] cap;
      logic [4:0] lat;
      logic [3:0] eo;
      logic [3:0] eoe;
      logic [3:0] m;
      int len;
      lat = 5'h00;
      repeat (4) @(negedge i_mclk);
      chk_pin({o_pin_oe, o_pin_out}, 8'h00);
      chk_pin({o_core_in, 3'h0, o_tdo_oe}, 8'h00);
      i_arst_n = 1'b1;
      nav(8'h00, 1);
      // one row per instruction, run back to back
      for (int k = 0; k < 9; k++)
      begin
         @(negedge i_mclk);
         i_pin_in = 4'(k * 3 + 5);
         i_core_out = 4'(k * 5 + 2);
         i_core_oe = k[0];
         pat = (64'h9e37_79b9_7f4a_7c15 >> k) & 64'hff_ffff_ffff;
         ir_load(rows[k].op, got);
         chk_ser(got, 64'h01);
         len = rows[k].kind == 2'h0 ? 32 : (rows[k].kind == 2'h1 ? 1 : 9);
         cap = rows[k].kind == 2'h0 ? ID : (rows[k].kind == 2'h1 ? 64'h0 :
            {55'h0, i_core_oe, i_core_out, i_pin_in});
         dr_rw(40, pat, got);
         chk_ser(got, stream(len, cap, pat));
         if (rows[k].kind == 2'h2)
            lat = pat[39:35];
         repeat (8) @(negedge i_mclk);
         eoe = rows[k].pins == 2'h1 ? {4{lat[4]}} : (rows[k].pins == 2'h2 ? 4'h0 : {4{i_core_oe}});
         eo = rows[k].pins == 2'h1 ? lat[3:0] : i_core_out;
         m = rows[k].pins == 2'h2 ? 4'h0 : 4'hf;
         chk_pin({o_pin_oe, o_pin_out & m}, {eoe, eo & m});
         chk_pin({4'h0, o_core_in}, {4'h0, i_pin_in});
      end
      // five high tms edges fall back to the identification instruction
      ir_load(`TAP_OP_BYPASS, got);
      nav(8'h1f, 6);
      dr_rw(32, 64'h0, got);
      chk_ser(got, ID);
      // reset in mid-run while the pins are driven from the latches
      ir_load(`TAP_OP_EXTEST, got);
      dr_rw(9, 64'h1f0, got);
      repeat (8) @(negedge i_mclk);
      chk_pin({o_pin_oe, o_pin_out}, 8'hff);
      i_arst_n = 1'b0;
      nav(8'h01, 1);
      @(negedge i_mclk);
      chk_pin({o_pin_oe, o_pin_out}, 8'h00);
      i_arst_n = 1'b1;
      nav(8'h00, 1);
      chk_pin({o_pin_oe, o_pin_out}, {{4{i_core_oe}}, i_core_out});
      dr_rw(32, 64'h0, got);
      chk_ser(got, ID);
      conclude();
   end
endmodule : tb
`default_nettype wire
